// File: rtl/apimr_pkg.sv
// Package for the power/idle command and identify-word block.
// Assumes a single 25 MHz core clock; shared constants and the sequencer state type.
package apimr_pkg;
    // Command codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
    localparam logic [7:0] CMD_IDLE_IMM_B = 8'he1;
    localparam logic [7:0] CMD_IDLE_A = 8'h97;
    localparam logic [7:0] CMD_IDLE_B = 8'he3;
    // Power requirement word field positions
    localparam int PWR_VALID_BIT = 15;
    localparam int PWR_RSV_BIT = 14;
    localparam int PWR_NOL1_BIT = 13;
    localparam int PWR_L1DIS_BIT = 12;
    localparam int PWR_CUR_W = 12;
    // Advanced timing word field positions (low bit of each field)
    localparam int IDE_PIO_SUP_LSB = 0;
    localparam int IDE_DMA_SUP_LSB = 3;
    localparam int IDE_PIO_SEL_LSB = 6;
    localparam int IDE_DMA_SEL_LSB = 9;
    localparam int CARD_IO_LSB = 0;
    localparam int CARD_MEM_LSB = 3;
    localparam int CARD_IOUDMA_LSB = 6;
    localparam int CARD_MEMUDMA_LSB = 9;
    localparam int CARD_UDMASEL_LSB = 12;
    localparam int CARD_UDMA_OK_BIT = 15;
    // Highest legal code in each 3-bit mode field
    localparam logic [2:0] ADV_MAX_CODE = 3'h2;
    localparam logic [2:0] CYC_MAX_CODE = 3'h3;
    localparam logic [2:0] UDMA_MAX_CODE = 3'h6;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 5000;
    localparam int DEFAULT_SLEEP_US = 20000;
    localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1000000);
    localparam int DEFAULT_SLEEP_TICKS = DEFAULT_SLEEP_US / TICK_US;
    // Reset values
    localparam logic [7:0] RST_SPT = 8'h00;
    localparam logic [3:0] RST_HEADS = 4'h0;
    // Command sequencer states; one bit changes per step except DONE to IDLE
    typedef enum logic [1:0] {
        APIMR_IDLE = 2'b00,
        APIMR_EXEC = 2'b01,
        APIMR_DONE = 2'b11
    } apimr_state_t;
endpackage

// File: rtl/apimr_core.sv
// Power requirement and advanced timing identify words, plus execution
// of Idle, Idle Immediate, Initialize Drive Parameters and NOP, with the
// automatic power-down timer.
// Assumes task-file values are stable and synchronous when cmdValid pulses.
//
// Summary of operation
// - Bit 15 flags valid power description
// - Bit 14 always reads zero
// - Bit 13 set when level-1 commands absent
// - Bit 12 set while level-1 commands disabled
// - Low twelve bits give maximum current mA
// - Bits 2-0 highest advanced PIO supported
// - Bits 5-3 highest advanced DMA supported
// - Bits 8-6 selected advanced PIO mode
// - Bits 11-9 selected advanced DMA mode
// - Timing word top four bits zero
// - Card bits 2-0 fastest I/O cycle
// - Card bits 5-3 fastest memory cycle
// - Card bits 8-6 max I/O UDMA
// - Card bits 11-9 max memory UDMA
// - Card bits 14-12 selected UDMA mode
// - Card bit 15 flags UDMA fields valid
// - Idle: busy, idle, release, interrupt
// - Nonzero count loads 5ms timer, zero disables
// - No idle command: sleep after 20ms
// - Idle immediate keeps timer setting, restarts countdown
// - Init params uses count and head nibble
// - Command zero always aborts
`timescale 1ns/100ps
module apimr_core #(
    parameter int TICK_CYC = apimr_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] sectorCount,
    input wire logic [7:0] driveHead,
    input wire logic powerDescValid,
    input wire logic noLevel1Cmds,
    input wire logic level1CmdsDisabled,
    input wire logic [11:0] maxCurrentMa,
    input wire logic [2:0] pioSupport,
    input wire logic [2:0] dmaSupport,
    input wire logic [2:0] pioSelect,
    input wire logic [2:0] dmaSelect,
    input wire logic udmaFieldsValid,
    input wire logic [2:0] ioCycleMode,
    input wire logic [2:0] memCycleMode,
    input wire logic [2:0] ioUdmaMax,
    input wire logic [2:0] memUdmaMax,
    input wire logic [2:0] udmaSelect,
    output logic [15:0] powerReqWord,
    output logic [15:0] ideTimingWord,
    output logic [15:0] cardTimingWord,
    output logic busy,
    output logic intrq,
    output logic cmdAbort,
    output logic cmdDone,
    output logic idleMode,
    output logic sleepMode,
    output logic autoPdEnabled,
    output logic [7:0] sectorsPerTrack,
    output logic [3:0] headsMinusOne
);
    // Command timing, counted from the edge that takes cmdValid:
    // edge 0 takes the task file and raises busy; edge 1 runs the
    // command (geometry and timer loads happen here); edge 2 drops
    // busy and pulses intrq and cmdDone for one cycle. cmdAbort then
    // stands until the next accepted command.
    // A strobe that arrives while busy is ignored without any flag; the
    // host is expected to poll busy, as it would the status register.
    // The identify words are pure functions of the capability inputs, so
    // a change of mode selection shows up in them on the same cycle.
    // Every register below freezes while clkEn is low, including the
    // power-down timer, so a gated clock also stretches the timeout.
    apimr_pkg::apimr_state_t state, next_state;
    // Held copies of the task file; the host may change its registers
    // as soon as busy rises, so execution never looks at the live pins.
    logic [7:0] cmdLatch;
    logic [7:0] countLatch;
    logic [7:0] headLatch;
    // Power-down countdown: ticks left, value to restart from, and the
    // cycle counter that divides the core clock down to one tick.
    logic [7:0] pdTicks;
    logic [7:0] pdReload;
    logic [22:0] tickCnt;
    logic timerRun;

    // Reserved codes are reported as zero so the host falls back to
    // the older words instead of reading a meaningless mode.
    // The limit is an input so one function serves all field kinds:
    // advanced modes stop at 2, cycle modes at 3, UDMA modes at 6.
    function automatic logic [2:0] clampCode(input logic [2:0] c,
                                             input logic [2:0] lim);
        clampCode = (c > lim) ? 3'h0 : c;
    endfunction

    // Decode of the held command
    // Decoding the latch rather than cmdCode keeps the command stable for
    // the whole two-cycle execution window.
    wire isIdle = (cmdLatch == apimr_pkg::CMD_IDLE_A) ||
                  (cmdLatch == apimr_pkg::CMD_IDLE_B);
    wire isIdleImm = (cmdLatch == apimr_pkg::CMD_IDLE_IMM_A) ||
                     (cmdLatch == apimr_pkg::CMD_IDLE_IMM_B);
    wire isInit = (cmdLatch == apimr_pkg::CMD_INIT_PARAMS);
    wire isNop = (cmdLatch == apimr_pkg::CMD_NOP);
    // A command is taken only in the idle state; see the timing note above.
    wire accept = cmdValid && (state == apimr_pkg::APIMR_IDLE);
    // Last cycle of one tick
    wire tickEnd = (tickCnt == 23'(TICK_CYC - 1));
    // The timer expires on the last cycle of its final tick; a count of
    // one therefore sleeps after one full tick, never early.
    wire expire = timerRun && tickEnd && (pdTicks == 8'h01);
    wire execIdle = (state == apimr_pkg::APIMR_EXEC) && isIdle;

    // Identify words, built combinationally from the capability inputs.
    // Nothing here is registered: the identify path samples them well
    // after any change settles. Reserved codes are forced to zero.
    always_comb begin
        powerReqWord = 16'h0000;
        powerReqWord[apimr_pkg::PWR_VALID_BIT] = powerDescValid;
        powerReqWord[apimr_pkg::PWR_RSV_BIT] = 1'b0;
        powerReqWord[apimr_pkg::PWR_NOL1_BIT] = noLevel1Cmds;
        powerReqWord[apimr_pkg::PWR_L1DIS_BIT] = level1CmdsDisabled;
        powerReqWord[apimr_pkg::PWR_CUR_W-1:0] = maxCurrentMa;
    end

    // Advanced IDE timing word
    always_comb begin
        ideTimingWord = 16'h0000;
        ideTimingWord[apimr_pkg::IDE_PIO_SUP_LSB +: 3] =
            clampCode(pioSupport, apimr_pkg::ADV_MAX_CODE);
        ideTimingWord[apimr_pkg::IDE_DMA_SUP_LSB +: 3] =
            clampCode(dmaSupport, apimr_pkg::ADV_MAX_CODE);
        ideTimingWord[apimr_pkg::IDE_PIO_SEL_LSB +: 3] =
            clampCode(pioSelect, apimr_pkg::ADV_MAX_CODE);
        ideTimingWord[apimr_pkg::IDE_DMA_SEL_LSB +: 3] =
            clampCode(dmaSelect, apimr_pkg::ADV_MAX_CODE);
    end

    // Advanced card timing word
    always_comb begin
        cardTimingWord = 16'h0000;
        cardTimingWord[apimr_pkg::CARD_IO_LSB +: 3] =
            clampCode(ioCycleMode, apimr_pkg::CYC_MAX_CODE);
        cardTimingWord[apimr_pkg::CARD_MEM_LSB +: 3] =
            clampCode(memCycleMode, apimr_pkg::CYC_MAX_CODE);
        cardTimingWord[apimr_pkg::CARD_IOUDMA_LSB +: 3] =
            clampCode(ioUdmaMax, apimr_pkg::UDMA_MAX_CODE);
        cardTimingWord[apimr_pkg::CARD_MEMUDMA_LSB +: 3] =
            clampCode(memUdmaMax, apimr_pkg::UDMA_MAX_CODE);
        cardTimingWord[apimr_pkg::CARD_UDMASEL_LSB +: 3] =
            clampCode(udmaSelect, apimr_pkg::UDMA_MAX_CODE);
        cardTimingWord[apimr_pkg::CARD_UDMA_OK_BIT] = udmaFieldsValid;
    end

    // Sequencer: accept, execute one cycle, complete
    // EXEC is the only cycle in which a command loads geometry or timer settings,
    // which keeps those loads to a single, well defined edge.
    always_comb begin
        case (state)
            apimr_pkg::APIMR_IDLE:
                next_state = accept ? apimr_pkg::APIMR_EXEC
                                    : apimr_pkg::APIMR_IDLE;
            apimr_pkg::APIMR_EXEC: next_state = apimr_pkg::APIMR_DONE;
            apimr_pkg::APIMR_DONE: next_state = apimr_pkg::APIMR_IDLE;
            default: next_state = apimr_pkg::APIMR_IDLE;
        endcase
    end

    // Busy is held from acceptance until completion
    // It comes straight from the state register, so it is glitch free.
    // busy window
    assign busy = (state != apimr_pkg::APIMR_IDLE);

    // State and task-file capture
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= apimr_pkg::APIMR_IDLE;
            cmdLatch <= 8'h00;
            countLatch <= 8'h00;
            headLatch <= 8'h00;
        end else if (clkEn) begin
            state <= next_state;
            if (accept) begin
                cmdLatch <= cmdCode;
                countLatch <= sectorCount;
                headLatch <= driveHead;
            end
        end
    end

    // Completion: interrupt and done pulse at busy release
    // Unknown codes end the same way as NOP, so the host always sees an
    // interrupt and never waits on a command this block cannot run.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intrq <= 1'b0;
            cmdDone <= 1'b0;
            cmdAbort <= 1'b0;
        end else if (clkEn) begin
            cmdDone <= (state == apimr_pkg::APIMR_DONE);
            intrq <= (state == apimr_pkg::APIMR_DONE);
            // zero code aborts; unknown codes abort too
            if (state == apimr_pkg::APIMR_DONE)
                cmdAbort <= isNop || !(isIdle || isIdleImm || isInit);
            else if (accept)
                cmdAbort <= 1'b0;
        end
    end

    // Drive geometry from Initialize Drive Parameters
    // The drive bit and the top nibble of the head register are ignored;
    // they select the device, not its geometry.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sectorsPerTrack <= apimr_pkg::RST_SPT;
            headsMinusOne <= apimr_pkg::RST_HEADS;
        end else if (clkEn && state == apimr_pkg::APIMR_EXEC && isInit) begin
            sectorsPerTrack <= countLatch;
            headsMinusOne <= headLatch[3:0];
        end
    end

    // Power mode: idle on idle commands, sleep when the timer runs out.
    // Any accepted command wakes the card back to idle.
    // A strobe that wakes the card is taken at once; no separate wake-up
    // delay is modelled here.
    // Acceptance outranks expiry, so a command arriving on the expiry
    // cycle leaves the card awake.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idleMode <= 1'b1;
            sleepMode <= 1'b0;
        end else if (clkEn) begin
            if (accept) begin
                idleMode <= 1'b1;
                sleepMode <= 1'b0;
            end else if (expire) begin
                idleMode <= 1'b0;
                sleepMode <= 1'b1;
            end
        end
    end

    // Power-down timer in 5 ms ticks. After reset it runs the default
    // 20 ms countdown until the host issues a timed idle.
    // Priority: an idle command's own load wins over the restart that its
    // acceptance caused one cycle earlier, and both win over counting.
    // Limitation: the tick counter is cleared on every load, so each
    // countdown is whole ticks measured from that load.
    // A zero count stops the timer outright; only a later nonzero idle
    // command can bring automatic power-down back.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timerRun <= 1'b1;
            autoPdEnabled <= 1'b1;
            pdReload <= 8'(apimr_pkg::DEFAULT_SLEEP_TICKS);
            pdTicks <= 8'(apimr_pkg::DEFAULT_SLEEP_TICKS);
            tickCnt <= 23'h000000;
        end else if (clkEn) begin
            if (execIdle) begin
                autoPdEnabled <= (countLatch != 8'h00);
                timerRun <= (countLatch != 8'h00);
                pdReload <= countLatch;
                pdTicks <= countLatch;
                tickCnt <= 23'h000000;
            end else if (accept && autoPdEnabled) begin
                timerRun <= 1'b1;
                pdTicks <= pdReload;
                tickCnt <= 23'h000000;
            end else if (timerRun) begin
                tickCnt <= tickEnd ? 23'h000000 : tickCnt + 23'h000001;
                if (tickEnd) begin
                    pdTicks <= pdTicks - 8'h01;
                    if (pdTicks == 8'h01)
                        timerRun <= 1'b0;
                end
            end
        end
    end
endmodule

// File: tb/apimr_checker_asserts.sv
// Assertions on the power/idle command block, bound to its top module.
// Assumes one clock, clkEn held high by the bench, reset active high.
`timescale 1ns/100ps
module apimr_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] sectorCount,
    input wire logic powerDescValid,
    input wire logic [11:0] maxCurrentMa,
    input wire logic [2:0] pioSupport,
    input wire logic [15:0] powerReqWord,
    input wire logic [15:0] ideTimingWord,
    input wire logic busy,
    input wire logic intrq,
    input wire logic cmdDone,
    input wire logic cmdAbort,
    input wire logic [7:0] sectorsPerTrack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A command is only taken while idle, so busy gates the strobe
    wire take = clkEn && cmdValid && !busy;
    wire [2:0] pioExp = (pioSupport > 3'h2) ? 3'h0 : pioSupport;
    property p_vld; powerReqWord[15] == powerDescValid; endproperty
    a_vld: assert property (p_vld) else $error("valid bit wrong");
    property p_rsv; powerReqWord[14] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_cur; powerReqWord[11:0] == maxCurrentMa; endproperty
    a_cur: assert property (p_cur) else $error("current field wrong");
    property p_top; ideTimingWord[15:12] == 4'h0; endproperty
    a_top: assert property (p_top) else $error("timing top bits set");
    property p_pio; ideTimingWord[2:0] == pioExp; endproperty
    a_pio: assert property (p_pio) else $error("pio support wrong");
    property p_seq; take |=> busy [*2] ##1 (!busy && intrq); endproperty
    a_seq: assert property (p_seq) else $error("busy sequence wrong");
    property p_done; intrq |-> cmdDone && $past(take, 3); endproperty
    a_done: assert property (p_done) else $error("stray interrupt");
    property p_abort; take && cmdCode == 8'h00 |-> ##3 cmdAbort; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_geom;
        take && cmdCode == 8'h91 |->
            ##3 sectorsPerTrack == $past(sectorCount, 3);
    endproperty
    a_geom: assert property (p_geom) else $error("geometry wrong");
endmodule
bind apimr_core apimr_checker chk (.core_clk, .sys_rst, .clkEn, .cmdValid,
    .cmdCode, .sectorCount, .powerDescValid, .maxCurrentMa, .pioSupport,
    .powerReqWord, .ideTimingWord, .busy, .intrq, .cmdDone, .cmdAbort,
    .sectorsPerTrack);

// File: tb/apimr_host.sv
// Host model writing one command at a time into the task file.
// Assumes the bench calls issue() and busy comes from the device.
`timescale 1ns/100ps
module apimr_host (
    input wire logic core_clk,
    input wire logic busy,
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic [7:0] sectorCount,
    output logic [7:0] driveHead
);
    // Quiet task file at time zero
    initial begin
        cmdValid = 1'b0;
        {cmdCode, sectorCount, driveHead} = 24'h0;
    end
    task automatic issue(input logic [7:0] c, s, h);
        // Wait for a cycle with busy low so the write is not lost
        forever begin
            @(posedge core_clk);
            #1;
            if (!busy) break;
        end
        cmdValid = 1'b1;
        {cmdCode, sectorCount, driveHead} = {c, s, h};
        @(posedge core_clk);
        #1;
        cmdValid = 1'b0;
        // Released file shows inverted junk, so stale reuse is caught
        {cmdCode, sectorCount, driveHead} = ~{c, s, h};
    endtask
endmodule

// File: tb/test_apimr_core.sv
// Self-checking bench for the power/idle command block.
// Assumes the host model drives the task file; word inputs come from here.
`timescale 1ns/100ps
module test_apimr_core;
    localparam int TICK = 4;
    logic core_clk, sys_rst, clkEn, busy, intrq, cmdAbort, cmdDone, cmdValid;
    logic idleMode, sleepMode, autoPdEnabled, udmaFieldsValid;
    logic powerDescValid, noLevel1Cmds, level1CmdsDisabled;
    logic [7:0] cmdCode, sectorCount, driveHead, sectorsPerTrack;
    logic [3:0] headsMinusOne;
    logic [11:0] maxCurrentMa;
    logic [2:0] pioSupport, dmaSupport, pioSelect, dmaSelect, ioCycleMode;
    logic [2:0] memCycleMode, ioUdmaMax, memUdmaMax, udmaSelect;
    logic [15:0] powerReqWord, ideTimingWord, cardTimingWord;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    // Short tick keeps the power-down waits to a few cycles
    apimr_core #(.TICK_CYC(TICK)) dut (.core_clk, .sys_rst, .clkEn,
        .cmdValid, .cmdCode, .sectorCount, .driveHead, .powerDescValid,
        .noLevel1Cmds, .level1CmdsDisabled, .maxCurrentMa, .pioSupport,
        .dmaSupport, .pioSelect, .dmaSelect, .udmaFieldsValid, .ioCycleMode,
        .memCycleMode, .ioUdmaMax, .memUdmaMax, .udmaSelect, .powerReqWord,
        .ideTimingWord, .cardTimingWord, .busy, .intrq, .cmdAbort, .cmdDone,
        .idleMode, .sleepMode, .autoPdEnabled, .sectorsPerTrack,
        .headsMinusOne);
    apimr_host host (.core_clk, .busy, .cmdValid, .cmdCode, .sectorCount,
        .driveHead);
    task automatic chk(input logic [15:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [2:0] lim(input logic [2:0] x, m);
        return (x > m) ? 3'h0 : x;
    endfunction
    // Issue one command and judge its completion cycle
    task automatic cmd(input logic [7:0] c, s, h, input logic ab);
        host.issue(c, s, h);
        repeat (2) @(posedge core_clk);
        #1;
        chk({cmdDone, intrq, busy, cmdAbort}, {3'b110, ab}, "completion");
        chk({idleMode, sleepMode}, 2'b10, "not awake");
    endtask
    // Sleep must not come before lo cycles, and must come by hi
    task automatic expect_sleep(input int lo, hi);
        repeat (lo) @(posedge core_clk);
        #1 chk(sleepMode, 1'b0, "slept early");
        for (int i = lo; i < hi && sleepMode !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        #1 chk({sleepMode, idleMode}, 2'b10, "no sleep");
    endtask
    task automatic t_words();
        logic [2:0] v [5];
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 5; k++)
                v[k] = 3'(i + k);
            {pioSupport, dmaSupport} = {v[0], v[1]};
            {pioSelect, dmaSelect} = {v[2], v[3]};
            {ioCycleMode, memCycleMode, ioUdmaMax} = {v[0], v[1], v[2]};
            {memUdmaMax, udmaSelect, udmaFieldsValid} = {v[3], v[4], v[0][0]};
            {powerDescValid, noLevel1Cmds, level1CmdsDisabled} = v[0];
            maxCurrentMa = {v[0], v[1], v[2], v[4]};
            #5;
            chk(powerReqWord, {v[0][2], 1'b0, v[0][1:0], maxCurrentMa},
                "pwr");
            chk(ideTimingWord, {4'h0, lim(v[3], 3'h2), lim(v[2], 3'h2),
                lim(v[1], 3'h2), lim(v[0], 3'h2)}, "ide");
            chk(cardTimingWord, {v[0][0], lim(v[4], 3'h6), lim(v[3], 3'h6),
                lim(v[2], 3'h6), lim(v[1], 3'h3), lim(v[0], 3'h3)},
                "card");
            @(posedge core_clk);
        end
    endtask
    task automatic t_idle();
        for (int i = 0; i < 2; i++) begin
            cmd(i ? 8'he3 : 8'h97, 8'h02, 8'h00, 1'b0);
            chk(autoPdEnabled, 1'b1, "pd off");
            expect_sleep(4, 12);
            cmd(i ? 8'he3 : 8'h97, 8'h00, 8'h00, 1'b0);
            chk(autoPdEnabled, 1'b0, "pd on");
            cmd(i ? 8'he1 : 8'h95, 8'h00, 8'h00, 1'b0);
            repeat (20) @(posedge core_clk);
            #1 chk({sleepMode, idleMode}, 2'b01, "slept while off");
            repeat (20) @(posedge core_clk);
            #1 chk({sleepMode, idleMode}, 2'b01, "slept while off");
        end
        cmd(8'h97, 8'h03, 8'h00, 1'b0);
        repeat (6) @(posedge core_clk);
        cmd(8'he1, 8'h00, 8'h00, 1'b0);
        chk(autoPdEnabled, 1'b1, "pd lost");
        expect_sleep(7, 16);
    endtask
    // Clock and cycle ceiling
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end
    initial begin
        {sys_rst, clkEn} = 2'b11;
        {pioSupport, dmaSupport, pioSelect, dmaSelect} = 12'h0;
        {ioCycleMode, memCycleMode, ioUdmaMax, memUdmaMax} = 12'h0;
        {udmaSelect, udmaFieldsValid, maxCurrentMa} = 16'h0;
        {powerDescValid, noLevel1Cmds, level1CmdsDisabled} = 3'h0;
        repeat (4) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        expect_sleep(12, 24);
        t_words();
        cmd(8'h00, 8'h00, 8'h00, 1'b1);
        cmd(8'h5a, 8'h00, 8'h00, 1'b1);
        cmd(8'h91, 8'h3f, 8'ha5, 1'b0);
        chk({sectorsPerTrack, headsMinusOne}, 12'h3f5, "geometry");
        t_idle();
        report_and_stop();
    end
endmodule
